// File: src/cgs_pkg.sv
/*
 * constants of the charge gauge status and control block: register offsets,
 * field positions and values after reset.
 * assumes an 8-bit register port with a 3-bit register index.
 */
package cgs_pkg;
	localparam logic [2:0]  OFS_FLAGS     = 3'h0;
	localparam logic [2:0]  OFS_SETUP     = 3'h1;
	localparam logic [2:0]  OFS_CHG_HI    = 3'h2;
	localparam logic [2:0]  OFS_CHG_LO    = 3'h3;
	localparam logic [2:0]  OFS_THH_HI    = 3'h4;
	localparam logic [2:0]  OFS_THH_LO    = 3'h5;
	localparam logic [2:0]  OFS_THL_HI    = 3'h6;
	localparam logic [2:0]  OFS_THL_LO    = 3'h7;

	// flag bit positions
	localparam int          FLG_ID        = 7;
	localparam int          FLG_SAT       = 5;
	localparam int          FLG_HIGH      = 3;
	localparam int          FLG_LOW       = 2;
	localparam int          FLG_VBAT      = 1;
	localparam int          FLG_DIP       = 0;
	// id bit value; arbitrary
	localparam logic        PART_ID_BIT   = 1'h1;
	// bits a read may clear, and bits that pull the alert pin
	localparam logic [7:0]  FLG_CLR_MASK  = 8'h2F;
	localparam logic [7:0]  FLG_ALRT_MASK = 8'h2E;

	// setup fields
	localparam int          SET_VBAT_LSB  = 6;
	localparam int          SET_PSC_LSB   = 3;
	localparam int          SET_PIN_LSB   = 1;
	localparam int          SET_SHDN      = 0;
	localparam logic [1:0]  PIN_ALERT     = 2'h2;
	localparam logic [1:0]  PIN_FULL      = 2'h1;
	localparam logic [7:0]  SETUP_RST     = 8'h3C;

	// charge limits, and charge, threshold and prescaler reset values
	localparam logic [15:0] CHG_RST       = 16'h7FFF;
	localparam logic [15:0] CHG_MAX       = 16'hFFFF;
	localparam logic [15:0] CHG_MIN       = 16'h0000;
	localparam logic [15:0] THH_RST       = 16'hFFFF;
	localparam logic [15:0] THL_RST       = 16'h0000;
	localparam logic [6:0]  PSC_RST       = 7'h00;
endpackage

// File: src/cgs_cnt_if.sv
/*
 * signals between the register side and the charge counter.
 * assumes both ends share sys_clk_in.
 */
`timescale 1ns/10ps
interface cgs_cnt_if;
	logic        run;
	logic        step;
	logic        step_up;
	logic [2:0]  psel;
	logic        wr_hi;
	logic        wr_lo;
	logic [7:0]  wdata;
	logic        set_full;
	logic [15:0] charge;

	modport ctrl (output run, step, step_up, psel, wr_hi, wr_lo, wdata, set_full, input charge);
	modport cnt  (input run, step, step_up, psel, wr_hi, wr_lo, wdata, set_full, output charge);
endinterface

// File: src/cgs_counter.sv
/*
 * prescaler and saturating 16-bit accumulated charge.
 * assumes step is a one-cycle pulse per integrator reversal.
 */
`timescale 1ns/10ps
module cgs_counter (
	// clock and reset
	input  wire logic  sys_clk_in,
	input  wire logic  rst_in,
	// control side
	cgs_cnt_if.cnt     c
);
	logic [6:0]  psc_r;
	logic [6:0]  psc_nxt;
	logic [15:0] chg_r;
	logic [15:0] chg_nxt;
	logic [6:0]  psc_top;

	assign c.charge = chg_r;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		psc_top = 7'((8'h01 << c.psel) - 8'h01);
		psc_nxt = psc_r;
		chg_nxt = chg_r;
		if (!c.run) begin
			psc_nxt = cgs_pkg::PSC_RST;
		end else if (c.step) begin
			if (c.step_up) begin
				if (psc_r >= psc_top) begin
					psc_nxt = cgs_pkg::PSC_RST;
					if (chg_r != cgs_pkg::CHG_MAX) begin
						chg_nxt = chg_r + 16'h0001;
					end
				end else begin
					psc_nxt = psc_r + 7'h01;
				end
			end else begin
				if (psc_r == 7'h00) begin
					psc_nxt = psc_top;
					if (chg_r != cgs_pkg::CHG_MIN) begin
						chg_nxt = chg_r - 16'h0001;
					end
				end else begin
					psc_nxt = psc_r - 7'h01;
				end
			end
		end
		// host and charger loads win over counting
		if (c.set_full) begin
			chg_nxt = cgs_pkg::CHG_MAX;
		end else begin
			if (c.wr_hi) begin
				chg_nxt[15:8] = c.wdata;
			end
			if (c.wr_lo) begin
				chg_nxt[7:0] = c.wdata;
			end
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			psc_r <= cgs_pkg::PSC_RST;
			chg_r <= cgs_pkg::CHG_RST;
		end else begin
			psc_r <= psc_nxt;
			chg_r <= chg_nxt;
		end
	end
endmodule

// File: src/cgs_top.sv
/*
 * status and control registers of a coulomb-counting charge gauge.
 * assumes a serial bus engine outside that turns bus transfers into one-cycle
 * register read and write strobes, and analog comparators synchronous to sys_clk_in.
 */
// Functional notes
// - flag bit 5 when charge hits limit
// - charge saturates at ends, no wrap
// - flag bit 3 when charge above high
// - flag bit 2 when charge below low
// - flag bit 1 on battery comparator low, setup 7:6 nonzero
// - supply dip sets bit 0, stops counting
// - resume from retained charge after dip
// - status read clears bits whose cause ended
// - alert mode pulls pin low on flags
// - bit 7 fixed part id, never cleared
// - setup 7:6 selects battery alert threshold
// - setup 2:1 selects dual-use pin mode
// - charge-complete high loads charge full
// - shutdown bit stops counting, drops residue
// - prescaler overflow steps charge by one
// - alert response releases the alert pin
// - reset loads mid-scale and threshold extremes
`timescale 1ns/10ps
module cgs_top (
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	// register port from the serial bus engine
	input  wire logic [2:0]  reg_addr_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [7:0]  reg_wdata_in,
	output logic      [7:0]  reg_rdata_out,
	input  wire logic        alert_resp_in,
	// analog front end
	input  wire logic        integ_rev_in,
	input  wire logic        integ_up_in,
	input  wire logic        vbat_below_in,
	input  wire logic        supply_dip_lockout_in,
	output logic      [1:0]  vbat_sel_out,
	output logic             analog_shdn_out,
	// dual-use pin
	input  wire logic        alert_or_full_pin_in,
	output logic             alert_or_full_pin_out,
	output logic             alert_or_full_pin_oe_out
);
	cgs_cnt_if   cif ();

	logic [7:0]  flags_r;
	logic [7:0]  flags_nxt;
	logic [7:0]  setup_r;
	logic [7:0]  setup_nxt;
	logic [15:0] thh_r;
	logic [15:0] thh_nxt;
	logic [15:0] thl_r;
	logic [15:0] thl_nxt;
	logic [7:0]  rdata_r;
	logic [7:0]  rdata_nxt;
	logic        alert_r;
	logic        alert_nxt;
	logic        pin_oe_r;
	logic        pin_oe_nxt;
	logic [7:0]  cond;
	logic [7:0]  fresh;
	logic        rd_flags;
	logic        alert_mode;
	logic        full_mode;

	function automatic logic wr_at(input logic [2:0] ofs);
		wr_at = reg_wr_in && (reg_addr_in == ofs);
	endfunction

	function automatic logic rd_at(input logic [2:0] ofs);
		rd_at = reg_rd_in && (reg_addr_in == ofs);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// counter hookup
	assign alert_mode   = setup_r[cgs_pkg::SET_PIN_LSB + 1];
	assign full_mode    = setup_r[cgs_pkg::SET_PIN_LSB];
	// dip and shutdown both halt counting; charge is kept so counting resumes
	assign cif.run      = !setup_r[cgs_pkg::SET_SHDN] && !supply_dip_lockout_in;
	assign cif.step     = integ_rev_in;
	assign cif.step_up  = integ_up_in;
	assign cif.psel     = setup_r[cgs_pkg::SET_PSC_LSB +: 3];
	assign cif.wr_hi    = wr_at(cgs_pkg::OFS_CHG_HI);
	assign cif.wr_lo    = wr_at(cgs_pkg::OFS_CHG_LO);
	assign cif.wdata    = reg_wdata_in;
	assign cif.set_full = full_mode && alert_or_full_pin_in;

	cgs_counter u_cnt (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.c          (cif)
	);

	////////////////////////////////////////////////////////////////////////////
	// flag conditions, evaluated every cycle
	always_comb begin
		cond = 8'h00;
		cond[cgs_pkg::FLG_SAT]  = (cif.charge == cgs_pkg::CHG_MAX) || (cif.charge == cgs_pkg::CHG_MIN);
		cond[cgs_pkg::FLG_HIGH] = cif.charge > thh_r;
		cond[cgs_pkg::FLG_LOW]  = cif.charge < thl_r;
		cond[cgs_pkg::FLG_VBAT] = vbat_below_in && (setup_r[cgs_pkg::SET_VBAT_LSB +: 2] != 2'h0);
		cond[cgs_pkg::FLG_DIP]  = supply_dip_lockout_in;
	end

	assign rd_flags = rd_at(cgs_pkg::OFS_FLAGS);
	assign fresh    = cond & ~flags_r & cgs_pkg::FLG_ALRT_MASK;

	////////////////////////////////////////////////////////////////////////////
	// status flags: sticky, cleared by a read once their cause is gone
	always_comb begin
		flags_nxt = flags_r;
		if (rd_flags) begin
			// a live condition keeps its bit, so set wins over the clear
			flags_nxt = flags_r & ~(cgs_pkg::FLG_CLR_MASK & ~cond);
		end
		flags_nxt = flags_nxt | (cond & cgs_pkg::FLG_CLR_MASK);
		flags_nxt[cgs_pkg::FLG_ID] = cgs_pkg::PART_ID_BIT;
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			flags_r <= {cgs_pkg::PART_ID_BIT, 7'h00};
		end else begin
			flags_r <= flags_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// setup and thresholds; each byte lands at once, no shadow for the pair
	always_comb begin
		setup_nxt = setup_r;
		// writes to the flags offset fall through untouched
		if (wr_at(cgs_pkg::OFS_SETUP)) begin
			setup_nxt = reg_wdata_in;
		end
		thh_nxt = thh_r;
		thl_nxt = thl_r;
		if (wr_at(cgs_pkg::OFS_THH_HI)) begin
			thh_nxt[15:8] = reg_wdata_in;
		end
		if (wr_at(cgs_pkg::OFS_THH_LO)) begin
			thh_nxt[7:0] = reg_wdata_in;
		end
		if (wr_at(cgs_pkg::OFS_THL_HI)) begin
			thl_nxt[15:8] = reg_wdata_in;
		end
		if (wr_at(cgs_pkg::OFS_THL_LO)) begin
			thl_nxt[7:0] = reg_wdata_in;
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			setup_r <= cgs_pkg::SETUP_RST;
			thh_r   <= cgs_pkg::THH_RST;
			thl_r   <= cgs_pkg::THL_RST;
		end else begin
			setup_r <= setup_nxt;
			thh_r   <= thh_nxt;
			thl_r   <= thl_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data, registered so the bus engine sees one stable byte per read
	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				cgs_pkg::OFS_FLAGS:  rdata_nxt = flags_r;
				cgs_pkg::OFS_SETUP:  rdata_nxt = setup_r;
				cgs_pkg::OFS_CHG_HI: rdata_nxt = cif.charge[15:8];
				cgs_pkg::OFS_CHG_LO: rdata_nxt = cif.charge[7:0];
				cgs_pkg::OFS_THH_HI: rdata_nxt = thh_r[15:8];
				cgs_pkg::OFS_THH_LO: rdata_nxt = thh_r[7:0];
				cgs_pkg::OFS_THL_HI: rdata_nxt = thl_r[15:8];
				cgs_pkg::OFS_THL_LO: rdata_nxt = thl_r[7:0];
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// alert pin: open drain, low while an alert is pending
	always_comb begin
		alert_nxt = alert_r;
		if (|fresh) begin
			alert_nxt = 1'b1;
		end else if (alert_resp_in) begin
			alert_nxt = 1'b0;
		end
		// bit 0 and bit 7 never drive the pin
		if (!(|(flags_nxt & cgs_pkg::FLG_ALRT_MASK))) begin
			alert_nxt = 1'b0;
		end
		pin_oe_nxt = alert_mode && alert_nxt;
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			alert_r  <= 1'b0;
			pin_oe_r <= 1'b0;
		end else begin
			alert_r  <= alert_nxt;
			pin_oe_r <= pin_oe_nxt;
		end
	end

	assign reg_rdata_out            = rdata_r;
	assign alert_or_full_pin_out    = 1'b0;
	assign alert_or_full_pin_oe_out = pin_oe_r;
	assign vbat_sel_out             = setup_r[cgs_pkg::SET_VBAT_LSB +: 2];
	assign analog_shdn_out          = setup_r[cgs_pkg::SET_SHDN];
endmodule

// File: verification/cgs_sva.sv
/* checker on the top ports of the gauge registers. assumes the bind at the foot. */
`timescale 1ns/10ps
module cgs_sva (
	// clock and reset
	input wire logic       sys_clk_in,
	input wire logic       rst_in,
	// register port and pins
	input wire logic [2:0] reg_addr_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic       supply_dip_lockout_in,
	input wire logic [1:0] vbat_sel_out,
	input wire logic       analog_shdn_out,
	input wire logic       alert_or_full_pin_in,
	input wire logic       alert_or_full_pin_out,
	input wire logic       alert_or_full_pin_oe_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	// shadow of setup, since the pin mode is not visible at the ports
	logic [7:0] set_r;
	logic [7:0] set_nxt;
	wire        rd_flg = reg_rd_in && reg_addr_in == cgs_pkg::OFS_FLAGS;
	always_comb begin
		set_nxt = set_r;
		if (reg_wr_in && reg_addr_in == cgs_pkg::OFS_SETUP) begin
			set_nxt = reg_wdata_in;
		end
	end
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			set_r <= cgs_pkg::SETUP_RST;
		end else begin
			set_r <= set_nxt;
		end
	end
	a_id_bit: assert property (rd_flg |=> reg_rdata_out[7:6] == 2'h2 && !reg_rdata_out[4])
		else $error("id or spare flag bits wrong");
	a_dip_flag: assert property (rd_flg && supply_dip_lockout_in && $past(supply_dip_lockout_in)
		&& !$past(rst_in) |=> reg_rdata_out[0]) else $error("dip flag missing");
	a_shdn_out: assert property (analog_shdn_out == set_r[0])
		else $error("shutdown output differs from setup");
	a_vbat_sel: assert property (vbat_sel_out == set_r[7:6])
		else $error("battery threshold select differs from setup");
	a_setup_read: assert property (reg_rd_in && reg_addr_in == 3'h1 |=> reg_rdata_out == $past(set_r))
		else $error("setup read back wrong");
	a_full_load: assert property (reg_rd_in && reg_addr_in == 3'h2 && $past(set_r[1]) && !$past(rst_in)
		&& $past(alert_or_full_pin_in) |=> reg_rdata_out == 8'hFF) else $error("charge not full");
	a_oe_mode: assert property ($rose(alert_or_full_pin_oe_out) |-> $past(set_r[2]) || $past(set_r[2], 2))
		else $error("pin pulled outside alert mode");
	a_pin_low: assert property (alert_or_full_pin_out == 1'h0)
		else $error("pin driven high");
endmodule

bind cgs_top cgs_sva u_sva (.sys_clk_in, .rst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
	.reg_rdata_out, .supply_dip_lockout_in, .vbat_sel_out, .analog_shdn_out, .alert_or_full_pin_in,
	.alert_or_full_pin_out, .alert_or_full_pin_oe_out);

// File: verification/cgs_host.sv
/* host model of the register port. assumes strobes are taken at rising edges. */
`timescale 1ns/10ps
module cgs_host (
	// clock and read data
	input  wire logic       sys_clk_in,
	input  wire logic [7:0] rdata_in,
	// strobes to the block
	output logic      [2:0] addr_out,
	output logic            wr_out,
	output logic            rd_out,
	output logic      [7:0] wdata_out,
	output logic            resp_out
);
	initial begin
		addr_out = 3'h0;
		wr_out = 1'h0;
		rd_out = 1'h0;
		wdata_out = 8'h00;
		resp_out = 1'h0;
	end
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'h1;
		@(posedge sys_clk_in);
		wr_out <= 1'h0;
		// released data shows the inverse, so a stale byte cannot pass
		wdata_out <= ~d;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge sys_clk_in);
		addr_out <= a;
		rd_out <= 1'h1;
		@(posedge sys_clk_in);
		rd_out <= 1'h0;
		#1;
		d = rdata_in;
	endtask
	task automatic resp();
		@(posedge sys_clk_in);
		resp_out <= 1'h1;
		@(posedge sys_clk_in);
		resp_out <= 1'h0;
	endtask
endmodule

// File: verification/charge_gauge_status_control_tb.sv
/* bench of the gauge registers. assumes cgs_pkg, cgs_host and the checker bind. */
`timescale 1ns/10ps
module charge_gauge_status_control_tb;
	logic        sys_clk_in = 1'h0, rst_in = 1'h1, rev = 1'h0, up = 1'h0;
	logic        vbat = 1'h0, dip = 1'h0, pin = 1'h0, wr, rd, resp, oe;
	logic [2:0]  addr;
	logic [7:0]  wdata, rdata, d, lf = 8'h3B;
	logic [15:0] ec;
	int          n_errors = 0, compares = 0, cyc = 0, s = 0;
	// open drain: the pin reads low while the block pulls it
	wire         pin_w = oe ? 1'h0 : pin;
	localparam logic [7:0] RV [8] = '{8'h80, 8'h3C, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
	always #2.5 sys_clk_in = ~sys_clk_in;
	cgs_host h (.sys_clk_in, .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata),
		.resp_out(resp));
	cgs_top dut (.sys_clk_in, .rst_in, .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .alert_resp_in(resp), .integ_rev_in(rev), .integ_up_in(up), .vbat_below_in(vbat),
		.supply_dip_lockout_in(dip), .vbat_sel_out(), .analog_shdn_out(), .alert_or_full_pin_in(pin_w),
		.alert_or_full_pin_out(), .alert_or_full_pin_oe_out(oe));
	function automatic logic [7:0] nx(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	// charge after k up-steps from 1000h at prescale four
	function automatic logic [15:0] ex(input int k);
		return 16'h1000 + 16'(k / 4);
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic rchk(input logic [2:0] a, input logic [7:0] e);
		h.rd(a, d);
		chk(d, e);
	endtask
	task automatic step(input logic u, input int k);
		repeat (k) begin
			@(posedge sys_clk_in);
			rev <= 1'h1;
			up <= u;
			@(posedge sys_clk_in);
			rev <= 1'h0;
		end
	endtask
	task automatic give_verdict();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc > 5000) begin
			n_errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge sys_clk_in);
		rst_in <= 1'h0;
		for (int i = 0; i < 8; i++) rchk(3'(i), RV[i]);
		h.wr(3'h0, 8'hFF);
		rchk(3'h0, 8'h80);
		h.wr(3'h1, 8'h04);
		h.wr(3'h2, 8'hFF);
		h.wr(3'h3, 8'hFE);
		step(1, 3);
		rchk(3'h3, 8'hFF);
		chk({7'h0, oe}, 8'h01);
		step(0, 1);
		rchk(3'h0, 8'hA0);
		rchk(3'h0, 8'h80);
		chk({7'h0, oe}, 8'h00);
		// steps in shutdown must vanish along with the prescaler residue
		h.wr(3'h1, 8'h14);
		h.wr(3'h2, 8'h10);
		h.wr(3'h3, 8'h00);
		step(1, 2);
		h.wr(3'h1, 8'h15);
		step(1, 5);
		h.wr(3'h1, 8'h14);
		for (int t = 0; t < 4; t++) begin
			lf = nx(lf);
			s += lf[4:0];
			step(1, lf[4:0]);
			ec = ex(s);
			rchk(3'h2, ec[15:8]);
			rchk(3'h3, ec[7:0]);
		end
		@(posedge sys_clk_in) dip <= 1'h1;
		step(1, 8);
		rchk(3'h0, 8'h81);
		@(posedge sys_clk_in) dip <= 1'h0;
		rchk(3'h3, ec[7:0]);
		rchk(3'h0, 8'h81);
		rchk(3'h0, 8'h80);
		// the residue left before the dip is gone, so three steps stay short
		step(1, 3);
		rchk(3'h3, ec[7:0]);
		step(1, 1);
		ec = ec + 16'h0001;
		rchk(3'h3, ec[7:0]);
		@(posedge sys_clk_in) vbat <= 1'h1;
		rchk(3'h0, 8'h80);
		h.wr(3'h1, 8'hC4);
		repeat (3) @(posedge sys_clk_in);
		#1;
		chk({7'h0, oe}, 8'h01);
		h.resp();
		repeat (2) @(posedge sys_clk_in);
		#1;
		chk({7'h0, oe}, 8'h00);
		@(posedge sys_clk_in) vbat <= 1'h0;
		rchk(3'h0, 8'h82);
		rchk(3'h0, 8'h80);
		h.wr(3'h4, 8'h0F);
		h.wr(3'h6, 8'h20);
		rchk(3'h0, 8'h8C);
		h.wr(3'h4, 8'hFF);
		h.wr(3'h6, 8'h00);
		rchk(3'h0, 8'h8C);
		rchk(3'h0, 8'h80);
		h.wr(3'h1, 8'h02);
		@(posedge sys_clk_in) pin <= 1'h1;
		h.wr(3'h3, 8'h00);
		rchk(3'h2, 8'hFF);
		rchk(3'h3, 8'hFF);
		chk({7'h0, oe}, 8'h00);
		@(posedge sys_clk_in) pin <= 1'h0;
		give_verdict();
	end
endmodule
